/* File: core/timer_pin_flag_sync_autostop.sv */
// Timer pin routing, request flags, start sync and auto-stop with an APB register file
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/10ps
`include "tmr_support_map.svh"

module timer_pin_flag_sync_autostop
  import tmr_support_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int NT = 5
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer pin A
  input wire logic timer_pin_a_in,
  output logic timer_pin_a_out,
  output logic timer_pin_a_oe,
  input wire logic shared_port_bit_a,
  input wire logic port_a_dir,
  // Timer pin B
  input wire logic timer_pin_b_in,
  output logic timer_pin_b_out,
  output logic timer_pin_b_oe,
  input wire logic port_b_latch,
  input wire logic port_b_dir,
  input wire logic pulse_width_out,
  // External interrupt pins
  input wire logic ext_irq_pin_first,
  input wire logic ext_irq_pin_second,
  // Counter side
  input wire logic [NT-1:0] tmr_underflow,
  input wire logic tmr1_src_pulse,
  input wire logic tmr3_src_pulse,
  output logic tmr1_count_pulse,
  output logic tmr3_count_pulse,
  // Core side
  input wire logic [NT-1:0] skip_req,
  input wire logic [NT-1:0] irq_ack,
  output logic [NT-1:0] skip_taken,
  output logic [NT-1:0] irq_req,
  output logic [NT-1:0] request_flags
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (NT != `NUM_TMR) begin : g_bad_nt
    $error("NT must equal the number of timers");
  end
  if (ADDR_W < 6) begin : g_bad_aw
    $error("ADDR_W too narrow for the register map");
  end

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic edge_ok(
    input logic prev,
    input logic cur,
    input ext_mode_s m
  );
    logic rise_e;
    logic fall_e;
    rise_e = cur & ~prev;
    fall_e = prev & ~cur;
    if (m.both) begin
      edge_ok = rise_e | fall_e;
    end else if (m.rise) begin
      edge_ok = rise_e;
    end else begin
      edge_ok = fall_e;
    end
  endfunction : edge_ok

  function automatic ext_mode_s ext_mode(input ctrl_t c);
    ext_mode_s m;
    m.enable = c[`EXT_SYNC_EN_BIT];
    m.rise = c[`EXT_RISE_BIT];
    m.both = c[`EXT_BOTH_BIT];
    ext_mode = m;
  endfunction : ext_mode

  function automatic logic src_is_pin(input ctrl_t c);
    src_is_pin = (c[`TMR_SRC_HI:`TMR_SRC_LO] == `SRC_PIN);
  endfunction : src_is_pin

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  ctrl_t pin_func_r;
  ctrl_t tmr1_ctrl_r;
  ctrl_t tmr2_ctrl_r;
  ctrl_t tmr3_ctrl_r;
  ctrl_t tmr4_ctrl_r;
  ctrl_t ext_first_r;
  ctrl_t ext_second_r;
  ctrl_t int_first_r;
  ctrl_t int_second_r;
  bus_state_e bus_state_r;
  logic [NT-1:0] flag_r;
  logic [NT-1:0] int_en;
  logic sync1_r;
  logic sync3_r;
  logic pin_a_prev_r;
  logic pin_b_prev_r;
  logic irq1_prev_r;
  logic irq2_prev_r;
  logic halve_r;
  logic wr_en;
  logic rd_en;
  logic hit;
  logic [31:0] rd_nxt;
  ext_mode_s mode1;
  ext_mode_s mode3;
  logic start1;
  logic start3;
  logic stop1;
  logic stop3;
  logic tmr1_ext;
  logic tmr3_ext;

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // One wait state: answer in the access cycle after the first
  assign wr_en = psel & penable & pwrite & (bus_state_r == BUS_IDLE);
  assign rd_en = psel & penable & ~pwrite & (bus_state_r == BUS_IDLE);

  always_comb begin
    hit = 1'b1;
    rd_nxt = 32'h0000_0000;
    if (paddr == ADDR_W'(`OFS_PIN_FUNC)) begin
      rd_nxt[3:0] = pin_func_r;
    end else if (paddr == ADDR_W'(`OFS_TMR1_CTRL)) begin
      rd_nxt[3:0] = tmr1_ctrl_r;
    end else if (paddr == ADDR_W'(`OFS_TMR2_CTRL)) begin
      rd_nxt[3:0] = tmr2_ctrl_r;
    end else if (paddr == ADDR_W'(`OFS_TMR3_CTRL)) begin
      rd_nxt[3:0] = tmr3_ctrl_r;
    end else if (paddr == ADDR_W'(`OFS_TMR4_CTRL)) begin
      rd_nxt[3:0] = tmr4_ctrl_r;
    end else if (paddr == ADDR_W'(`OFS_EXT_FIRST)) begin
      rd_nxt[3:0] = ext_first_r;
    end else if (paddr == ADDR_W'(`OFS_EXT_SECOND)) begin
      rd_nxt[3:0] = ext_second_r;
    end else if (paddr == ADDR_W'(`OFS_INT_FIRST)) begin
      rd_nxt[3:0] = int_first_r;
    end else if (paddr == ADDR_W'(`OFS_INT_SECOND)) begin
      rd_nxt[3:0] = int_second_r;
    end else if (paddr == ADDR_W'(`OFS_FLAGS)) begin
      rd_nxt[NT-1:0] = flag_r;
    end else if (paddr == ADDR_W'(`OFS_SYNC_STAT)) begin
      rd_nxt[1:0] = {sync3_r, sync1_r};
    end else begin
      hit = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_state_r <= BUS_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      case (bus_state_r)
        BUS_IDLE: begin
          pready <= psel & penable;
          pslverr <= psel & penable & ~hit;
          prdata <= rd_en ? rd_nxt : 32'h0000_0000;
          if (psel && penable) begin
            bus_state_r <= BUS_RESP;
          end
        end
        BUS_RESP: begin
          pready <= 1'b0;
          pslverr <= 1'b0;
          bus_state_r <= BUS_IDLE;
        end
        default: begin
          bus_state_r <= BUS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Control register writes
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_func_r <= `CTRL_RST;
      tmr1_ctrl_r <= `CTRL_RST;
      tmr2_ctrl_r <= `CTRL_RST;
      tmr3_ctrl_r <= `CTRL_RST;
      tmr4_ctrl_r <= `CTRL_RST;
      ext_first_r <= `CTRL_RST;
      ext_second_r <= `CTRL_RST;
      int_first_r <= `CTRL_RST;
      int_second_r <= `CTRL_RST;
    end else if (wr_en) begin
      if (paddr == ADDR_W'(`OFS_PIN_FUNC)) begin
        pin_func_r <= pwdata[3:0];
      end else if (paddr == ADDR_W'(`OFS_TMR1_CTRL)) begin
        tmr1_ctrl_r <= pwdata[3:0];
      end else if (paddr == ADDR_W'(`OFS_TMR2_CTRL)) begin
        tmr2_ctrl_r <= pwdata[3:0];
      end else if (paddr == ADDR_W'(`OFS_TMR3_CTRL)) begin
        tmr3_ctrl_r <= pwdata[3:0];
      end else if (paddr == ADDR_W'(`OFS_TMR4_CTRL)) begin
        tmr4_ctrl_r <= pwdata[3:0];
      end else if (paddr == ADDR_W'(`OFS_EXT_FIRST)) begin
        ext_first_r <= pwdata[3:0];
      end else if (paddr == ADDR_W'(`OFS_EXT_SECOND)) begin
        ext_second_r <= pwdata[3:0];
      end else if (paddr == ADDR_W'(`OFS_INT_FIRST)) begin
        int_first_r <= pwdata[3:0];
      end else if (paddr == ADDR_W'(`OFS_INT_SECOND)) begin
        int_second_r <= pwdata[3:0];
      end
    end
  end

  // ----------------------------------------
  // Edge history of pins
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_a_prev_r <= 1'b0;
      pin_b_prev_r <= 1'b0;
      irq1_prev_r <= 1'b0;
      irq2_prev_r <= 1'b0;
    end else begin
      pin_a_prev_r <= timer_pin_a_in;
      pin_b_prev_r <= timer_pin_b_in;
      irq1_prev_r <= ext_irq_pin_first;
      irq2_prev_r <= ext_irq_pin_second;
    end
  end

  // ----------------------------------------
  // Start sync latches and auto-stop
  // ----------------------------------------
  assign mode1 = ext_mode(ext_first_r);
  assign mode3 = ext_mode(ext_second_r);
  // Same trigger as the external interrupt of each pin
  assign start1 = mode1.enable & edge_ok(irq1_prev_r, ext_irq_pin_first, mode1);
  assign start3 = mode3.enable & edge_ok(irq2_prev_r, ext_irq_pin_second, mode3);
  // Auto-stop only counts while start sync is on
  assign stop1 = tmr1_ctrl_r[`TMR_OPT_BIT] & mode1.enable & tmr_underflow[0];
  assign stop3 = tmr3_ctrl_r[`TMR_OPT_BIT] & mode3.enable & tmr_underflow[2];

  // A fresh edge in the underflow cycle re-arms, so no trigger is lost
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_r <= 1'b0;
    end else if (!mode1.enable) begin
      sync1_r <= 1'b0;
    end else if (start1) begin
      sync1_r <= 1'b1;
    end else if (stop1) begin
      sync1_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync3_r <= 1'b0;
    end else if (!mode3.enable) begin
      sync3_r <= 1'b0;
    end else if (start3) begin
      sync3_r <= 1'b1;
    end else if (stop3) begin
      sync3_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Count pulses to timers 1 and 3
  // ----------------------------------------
  assign tmr1_ext = src_is_pin(tmr1_ctrl_r);
  assign tmr3_ext = src_is_pin(tmr3_ctrl_r);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tmr1_count_pulse <= 1'b0;
      tmr3_count_pulse <= 1'b0;
    end else begin
      tmr1_count_pulse <= (tmr1_ext ? (timer_pin_a_in & ~pin_a_prev_r) : tmr1_src_pulse)
        & (~mode1.enable | sync1_r);
      tmr3_count_pulse <= (tmr3_ext ? (timer_pin_b_in & ~pin_b_prev_r) : tmr3_src_pulse)
        & (~mode3.enable | sync3_r);
    end
  end

  // ----------------------------------------
  // Pin A: halved underflow output
  // ----------------------------------------
  // Timer 2 control bit 3 picks timer 2 over timer 1 as toggle source
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      halve_r <= 1'b0;
    end else if (tmr2_ctrl_r[`TMR_OPT_BIT] ? tmr_underflow[1] : tmr_underflow[0]) begin
      halve_r <= ~halve_r;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_pin_a_out <= 1'b0;
      timer_pin_a_oe <= 1'b0;
    end else if (pin_func_r[`PIN_A_TIMER_BIT]) begin
      timer_pin_a_out <= halve_r;
      timer_pin_a_oe <= ~tmr1_ext;
    end else begin
      timer_pin_a_out <= shared_port_bit_a;
      timer_pin_a_oe <= port_a_dir;
    end
  end

  // ----------------------------------------
  // Pin B: pulse width output
  // ----------------------------------------
  // Waveform is ORed with the port latch, which must therefore be low
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_pin_b_out <= 1'b0;
      timer_pin_b_oe <= 1'b0;
    end else begin
      timer_pin_b_out <= port_b_latch | (tmr4_ctrl_r[`TMR_OPT_BIT] & pulse_width_out);
      timer_pin_b_oe <= ~tmr3_ext & (port_b_dir | tmr4_ctrl_r[`TMR_OPT_BIT]);
    end
  end

  // ----------------------------------------
  // Request flags, interrupt or skip
  // ----------------------------------------
  assign int_en = {int_second_r[`INT_FIRST_T5_BIT], int_first_r};

  for (genvar i = 0; i < NT; i++) begin : g_flag
    // Underflow in the clearing cycle wins, so no event is lost
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        flag_r[i] <= 1'b0;
      end else if (tmr_underflow[i]) begin
        flag_r[i] <= 1'b1;
      end else if (irq_ack[i] || (skip_req[i] && flag_r[i])) begin
        flag_r[i] <= 1'b0;
      end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        skip_taken[i] <= 1'b0;
        irq_req[i] <= 1'b0;
        request_flags[i] <= 1'b0;
      end else begin
        skip_taken[i] <= skip_req[i] & flag_r[i];
        irq_req[i] <= (flag_r[i] | tmr_underflow[i]) & int_en[i] & ~irq_ack[i];
        request_flags[i] <= flag_r[i] | tmr_underflow[i];
      end
    end
  end

endmodule : timer_pin_flag_sync_autostop

/* File: core/tmr_support_map.svh */
// Register offsets, field positions and reset values of the timer support block
//
// Behaviour
// - Pin A takes timer 1 pin counts and outputs timer 1 or 2 underflow halved.
// - Pin B takes timer 3 pin counts and outputs the timer 4 pulse width waveform.
// - Pin function bit 0 picks general port or timer pin for pin A.
// - Timer 4 control bit 3 ORs the pulse width waveform with the port latch on pin B.
// - With pin A as source, timer 1 counts each rising edge of pin A.
// - With pin B as source, timer 3 counts each rising edge of pin B.
// - With pin B as timer 3 source, pin B driver is off.
// - Each of five timers sets its own request flag on underflow; skip tests it.
// - Two interrupt control registers choose interrupt or skip per flag.
// - A flag clears when its interrupt is taken or its skip succeeds.
// - External pin control one bit 0 enables start sync of timer 1 by irq pin one.
// - External pin control two bit 0 enables start sync of timer 3 by irq pin two.
// - A valid irq pin edge sets the sync latch; only then count pulses pass.
// - The sync latch trigger equals the external interrupt trigger condition.
// - A set sync latch holds until its enable bit clears, auto-stop clears it on underflow, or reset.
// - With auto-stop, the timer underflow clears its sync latch.
// - Control bit 3 of timers 1 and 3 enables auto-stop, blocking further counts.
// - Auto-stop acts only while start sync of that timer is enabled.
// - Underflow is a count pulse at zero; it sets the flag and triggers auto-stop.
`ifndef TMR_SUPPORT_MAP_SVH
`define TMR_SUPPORT_MAP_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_PIN_FUNC 8'h00
`define OFS_TMR1_CTRL 8'h04
`define OFS_TMR2_CTRL 8'h08
`define OFS_TMR3_CTRL 8'h0C
`define OFS_TMR4_CTRL 8'h10
`define OFS_EXT_FIRST 8'h14
`define OFS_EXT_SECOND 8'h18
`define OFS_INT_FIRST 8'h1C
`define OFS_INT_SECOND 8'h20
`define OFS_FLAGS 8'h24
`define OFS_SYNC_STAT 8'h28

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PIN_A_TIMER_BIT 0
`define TMR_SRC_LO 0
`define TMR_SRC_HI 1
`define TMR_RUN_BIT 2
`define TMR_OPT_BIT 3
`define EXT_SYNC_EN_BIT 0
`define EXT_RISE_BIT 1
`define EXT_BOTH_BIT 2
`define INT_FIRST_T5_BIT 0

// ----------------------------------------
// Codes and reset values
// ----------------------------------------
`define SRC_PIN 2'h3
`define CTRL_RST 4'h0
`define NUM_TMR 5

`endif

/* File: core/tmr_support_pkg.sv */
// Types shared by the timer support block
package tmr_support_pkg;

  typedef logic [3:0] ctrl_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_RESP = 2'b10
  } bus_state_e;

  typedef struct packed {
    logic enable;
    logic rise;
    logic both;
  } ext_mode_s;

  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_s;

endpackage : tmr_support_pkg

/* File: verif/testbench.sv */
// Self-checking bench for the timer support block
`timescale 1ns/10ps
`include "tmr_support_map.svh"
module testbench
  import tmr_support_pkg::*;
;
  logic core_clk, arst_n, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic timer_pin_a_in, timer_pin_a_out, timer_pin_a_oe, shared_port_bit_a, port_a_dir;
  logic timer_pin_b_in, timer_pin_b_out, timer_pin_b_oe, port_b_latch, port_b_dir, pulse_width_out;
  logic [1:0] irqp, src, cp;
  logic [4:0] uf, skip_req, irq_ack, skip_taken, irq_req, request_flags;
  int fails, compares;
  int n [2];
  timer_pin_flag_sync_autostop i_timer_pin_flag_sync_autostop (
    .core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_pin_a_in(timer_pin_a_in), .timer_pin_a_out(timer_pin_a_out), .timer_pin_a_oe(timer_pin_a_oe),
    .shared_port_bit_a(shared_port_bit_a), .port_a_dir(port_a_dir), .timer_pin_b_in(timer_pin_b_in),
    .timer_pin_b_out(timer_pin_b_out), .timer_pin_b_oe(timer_pin_b_oe), .port_b_latch(port_b_latch),
    .port_b_dir(port_b_dir), .pulse_width_out(pulse_width_out), .ext_irq_pin_first(irqp[0]),
    .ext_irq_pin_second(irqp[1]), .tmr_underflow(uf), .tmr1_src_pulse(src[0]), .tmr3_src_pulse(src[1]),
    .tmr1_count_pulse(cp[0]), .tmr3_count_pulse(cp[1]), .skip_req(skip_req), .irq_ack(irq_ack),
    .skip_taken(skip_taken), .irq_req(irq_req), .request_flags(request_flags)
  );
  // -------------------
  // Clock and counters
  // -------------------
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Sampled mid-cycle so edge updates never race the count
  always @(negedge core_clk) begin
    if (cp[0]) n[0]++;
    if (cp[1]) n[1]++;
  end
  // -------------------
  // Tasks
  // -------------------
  task automatic tick(input int c);
    repeat (c) @(posedge core_clk);
  endtask : tick
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic end_of_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test
  task automatic do_reset();
    arst_n <= 1'b0;
    tick(4);
    arst_n <= 1'b1;
    tick(1);
  endtask : do_reset
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    tick(1);
    penable <= 1'b1;
    // Waits for the answer however long it takes; only the watchdog ends a hang
    do begin
      tick(1);
    end while (pready !== 1'b1);
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    tick(1);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(s, e, q);
  endtask : rdc
  task automatic kick(input int t); // No reload or prescaler access
    uf[2 * t] <= 1'b1;
    tick(1);
    uf <= 5'h0;
    tick(2);
  endtask : kick
  task automatic srcp(input int t, input int c, input int e);
    int k;
    k = n[t];
    repeat (c) begin
      src[t] <= 1'b1;
      tick(1);
      src[t] <= 1'b0;
      tick(2);
    end
    tick(2);
    chk("count pulses", 32'(e), 32'(n[t] - k));
  endtask : srcp
  task automatic t_regs();
    for (int i = 1; i < 5; i++) begin
      rdc("ctrl reset", 8'(4 * i), 32'h0);
      wr(8'(4 * i), 32'hFFFF_FFFF);
      rdc("ctrl bits", 8'(4 * i), 32'h0000_000F);
      chk("slverr ok", 32'h0, 32'(er));
    end
    wr(`OFS_FLAGS, 32'hFFFF_FFFF);
    rdc("flags ro", `OFS_FLAGS, 32'h0);
    wr(8'h2C, 32'hFFFF_FFFF);
    chk("slverr", 32'h1, 32'(er));
    rdc("unmapped", 8'h2C, 32'h0);
    $display("test regs done");
  endtask : t_regs
  task automatic t_flags();
    logic [4:0] b;
    for (int i = 0; i < 5; i++) begin
      b = 5'(1 << i);
      skip_req <= b;
      tick(1);
      skip_req <= 5'h0;
      uf <= b;
      tick(1);
      chk("skip clear flag", 32'h0, 32'(skip_taken));
      skip_req <= b;
      uf <= 5'h0;
      tick(1);
      chk("flag set", 32'(b), 32'(request_flags));
      skip_req <= 5'h0;
      tick(1);
      chk("skip taken", 32'(b), 32'(skip_taken));
      tick(1);
      chk("flag cleared", 32'h0, 32'(request_flags));
    end
    $display("test flags done");
  endtask : t_flags
  task automatic t_irq();
    wr(`OFS_INT_FIRST, 32'hF);
    wr(`OFS_INT_SECOND, 32'h1);
    uf <= 5'h1F;
    tick(1);
    uf <= 5'h0;
    tick(1);
    chk("irq all", 32'h1F, 32'(irq_req));
    rdc("flag reg", `OFS_FLAGS, 32'h1F);
    irq_ack <= 5'h1F;
    tick(1);
    irq_ack <= 5'h0;
    tick(1);
    chk("irq dropped", 32'h0, 32'(irq_req));
    tick(1);
    chk("flags acked", 32'h0, 32'(request_flags));
    wr(`OFS_INT_FIRST, 32'h0);
    uf <= 5'h1;
    tick(1);
    uf <= 5'h0;
    tick(1);
    chk("masked irq", 32'h0, 32'(irq_req));
    skip_req <= 5'h1;
    tick(1);
    skip_req <= 5'h0;
    tick(1);
    chk("masked skip", 32'h1, 32'(skip_taken));
    $display("test irq done");
  endtask : t_irq
  task automatic t_pins();
    logic [4:0] pat [4];
    int k0, k1;
    pat = '{5'h1, 5'h2, 5'h0, 5'h2};
    do_reset();
    shared_port_bit_a <= 1'b1;
    port_a_dir <= 1'b1;
    port_b_dir <= 1'b1;
    pulse_width_out <= 1'b1;
    tick(2);
    chk("pa port out", 32'h1, 32'(timer_pin_a_out));
    chk("pa port oe", 32'h1, 32'(timer_pin_a_oe));
    chk("pb no pwm", 32'h0, 32'(timer_pin_b_out));
    chk("pb port oe", 32'h1, 32'(timer_pin_b_oe));
    shared_port_bit_a <= 1'b0;
    wr(`OFS_PIN_FUNC, 32'h1);
    wr(`OFS_TMR4_CTRL, 32'h8);
    kick(0);
    chk("pa halved", 32'h1, 32'(timer_pin_a_out));
    chk("pb pwm", 32'h1, 32'(timer_pin_b_out));
    wr(`OFS_TMR2_CTRL, 32'h8);
    for (int i = 0; i < 4; i++) begin
      uf <= pat[i];
      tick(1);
    end
    uf <= 5'h0;
    pulse_width_out <= 1'b0;
    tick(2);
    chk("pa tmr2 halved", 32'h1, 32'(timer_pin_a_out));
    chk("pb pwm low", 32'h0, 32'(timer_pin_b_out));
    port_b_latch <= 1'b1;
    tick(2);
    chk("pb latch", 32'h1, 32'(timer_pin_b_out));
    wr(`OFS_TMR1_CTRL, 32'h7);
    wr(`OFS_TMR3_CTRL, 32'h7);
    k0 = n[0];
    k1 = n[1];
    repeat (3) begin
      {timer_pin_a_in, timer_pin_b_in} <= 2'b11;
      tick(2);
      {timer_pin_a_in, timer_pin_b_in} <= 2'b00;
      tick(2);
    end
    tick(2);
    chk("pa counts", 32'(k0 + 3), 32'(n[0]));
    chk("pb counts", 32'(k1 + 3), 32'(n[1]));
    chk("pa oe input", 32'h0, 32'(timer_pin_a_oe));
    chk("pb oe off", 32'h0, 32'(timer_pin_b_oe));
    $display("test pins done");
  endtask : t_pins
  task automatic t_sync(input int t);
    logic [7:0] ca, ea;
    ca = t ? `OFS_TMR3_CTRL : `OFS_TMR1_CTRL;
    ea = t ? `OFS_EXT_SECOND : `OFS_EXT_FIRST;
    irqp <= 2'b00;
    do_reset();
    wr(ca, 32'hC);
    wr(ea, 32'h3);
    srcp(t, 2, 0);
    irqp[t] <= 1'b1;
    tick(3);
    rdc("latch set", `OFS_SYNC_STAT, 32'(1 << t));
    srcp(t, 2, 2);
    kick(t);
    rdc("auto-stop", `OFS_SYNC_STAT, 32'h0);
    srcp(t, 2, 0);
    wr(ca, 32'h4);
    irqp[t] <= 1'b0;
    tick(3);
    rdc("fall ignored", `OFS_SYNC_STAT, 32'h0);
    irqp[t] <= 1'b1;
    tick(3);
    kick(t);
    rdc("latch holds", `OFS_SYNC_STAT, 32'(1 << t));
    wr(ea, 32'h0);
    rdc("latch off", `OFS_SYNC_STAT, 32'h0);
    wr(ea, 32'h1);
    irqp[t] <= 1'b0;
    tick(3);
    rdc("fall edge", `OFS_SYNC_STAT, 32'(1 << t));
    wr(ea, 32'h0);
    wr(ea, 32'h5);
    irqp[t] <= 1'b1;
    tick(3);
    rdc("both edges", `OFS_SYNC_STAT, 32'(1 << t));
    wr(ea, 32'h0);
    wr(ca, 32'hC);
    kick(t);
    srcp(t, 2, 2);
    $display("test sync done");
  endtask : t_sync
  // -------------------
  // Main and watchdog
  // -------------------
  initial begin
    {arst_n, psel, penable, pwrite, paddr, pwdata, timer_pin_a_in, shared_port_bit_a} = '0;
    {port_a_dir, timer_pin_b_in, port_b_latch, port_b_dir, pulse_width_out, irqp, src} = '0;
    {uf, skip_req, irq_ack} = '0;
    do_reset();
    t_regs();
    t_flags();
    t_irq();
    t_pins();
    t_sync(0);
    t_sync(1);
    end_of_test();
  end
  // Whole run is a few hundred cycles; this cuts a hang
  initial begin
    tick(20000);
    fails++;
    end_of_test();
  end
endmodule : testbench

/* File: verif/tmr_support_properties.sv */
// Port-level assertions for the timer support block
`timescale 1ns/10ps
module tmr_support_checker
  import tmr_support_pkg::*;
#(
  parameter int NT = 5
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // APB handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Flags and core side
  input wire logic [NT-1:0] tmr_underflow,
  input wire logic [NT-1:0] skip_req,
  input wire logic [NT-1:0] irq_ack,
  input wire logic [NT-1:0] skip_taken,
  input wire logic [NT-1:0] irq_req,
  input wire logic [NT-1:0] request_flags
);
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held too long");
  // The answer comes on the second access edge, never sooner
  property p_ready_time;
    psel && $rose(penable) |-> !pready ##1 pready;
  endproperty
  a_ready_time: assert property (p_ready_time) else $error("pready off its slot");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
  property p_flag_set;
    |tmr_underflow |=> (request_flags & $past(tmr_underflow)) == $past(tmr_underflow);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("underflow left flag low");
  property p_skip_cause;
    |skip_taken |-> (skip_taken & ~($past(skip_req) & $past(request_flags))) == '0;
  endproperty
  a_skip_cause: assert property (p_skip_cause) else $error("skip on a clear flag");
  // A fresh underflow wins over the clear, so it is kept out
  property p_skip_clear;
    skip_taken[0] && !tmr_underflow[0] && !$past(tmr_underflow[0]) |=> !request_flags[0];
  endproperty
  a_skip_clear: assert property (p_skip_clear) else $error("flag kept after skip");
  property p_ack_drop;
    irq_ack[1] && !tmr_underflow[1] |=> !irq_req[1];
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("irq kept after ack");
  property p_irq_subset;
    (irq_req & ~request_flags) == '0;
  endproperty
  a_irq_subset: assert property (p_irq_subset) else $error("irq without flag");
endmodule : tmr_support_checker

bind timer_pin_flag_sync_autostop tmr_support_checker #(.NT(NT)) i_tmr_support_checker (
  .core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .tmr_underflow(tmr_underflow), .skip_req(skip_req), .irq_ack(irq_ack),
  .skip_taken(skip_taken), .irq_req(irq_req), .request_flags(request_flags)
);
